/* core/acc_calibration_control.sv */
// calibration sequencer, pin synchronisers and apb register file
// assumes core_clk_i is the sample clock and reset marks power-up
//
// Our own choices: the placing of the registers and register access over APB.
`default_nettype none
`include "acc_regs.svh"

module acc_calibration_control #(
  parameter logic [31:0] DLY_SHORT_CYC = `ACC_DLY_SHORT,
  parameter logic [31:0] DLY_LONG_CYC = `ACC_DLY_LONG
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // control pins
  input wire logic cal_request_i,
  input wire logic full_power_down_i,
  input wire logic calibration_delay_select_i,
  input wire logic output_edge_select_i,
  input wire logic extended_mode_i,
  input wire logic dual_edge_i,
  // sample data and output bus
  input wire logic [7:0] sample_data_i,
  output logic [7:0] output_data_o,
  output logic output_data_clock_o,
  // status
  output acc_pkg::acc_state_t cal_state_o,
  output logic calibration_active_o,
  output logic analog_power_down_o,
  output logic irq_o
);
  import acc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic req_s;
  logic dn_s;
  logic dsel_s;
  logic edge_s;
  logic ext_s;
  logic dual_s;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {dual_edge_i, extended_mode_i, output_edge_select_i,
                   calibration_delay_select_i, full_power_down_i, cal_request_i};
      pin_sync <= pin_meta;
    end
  end

  assign req_s = pin_sync[0];
  assign dn_s = pin_sync[1];
  assign dsel_s = pin_sync[2];
  assign edge_s = pin_sync[3];
  assign ext_s = pin_sync[4];
  assign dual_s = pin_sync[5];

  // ----------------------------------------
  // request filter and output edge
  // ----------------------------------------
  logic deb_start;

  acc_req_debounce u_debounce (
    .core_clk_i (core_clk_i),
    .arst_n_i (arst_n_i),
    .req_i (req_s),
    .start_o (deb_start)
  );

  acc_edge_align u_edge (
    .core_clk_i (core_clk_i),
    .arst_n_i (arst_n_i),
    .edge_sel_i (edge_s),
    .data_i (sample_data_i),
    .data_o (output_data_o),
    .data_clk_o (output_data_clock_o)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  acc_state_t state;
  acc_state_t next_state;
  logic [1:0] sync_cnt;
  logic [31:0] dly_cnt;
  logic [31:0] dly_limit;
  logic [15:0] cal_cnt;
  logic [15:0] cal_len;
  logic [3:0] irq_mask;
  logic [3:0] irq_status;
  logic [3:0] ev;
  logic sw_cal;
  logic cal_go;
  logic dly_done;
  logic cal_last;
  logic wr_en;
  logic rd_setup;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i;
  assign cal_go = deb_start || sw_cal;

  // extended mode takes the short delay whatever the select pin says
  always_comb begin
    if (ext_s) dly_limit = DLY_SHORT_CYC;
    else if (dsel_s) dly_limit = DLY_LONG_CYC;
    else dly_limit = DLY_SHORT_CYC;
  end

  assign dly_done = (dly_cnt >= dly_limit - 32'h1) && !dn_s;
  assign cal_last = (cal_cnt >= cal_len - 16'h1) || (cal_len == 16'h0);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // no edges means no progress: the walk from reset is the same whenever
  // the clock starts, which keeps power-up behaviour clock independent
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SYNC: begin
        if (sync_cnt == `ACC_SYNC_FILL) begin
          if (req_s) next_state = ST_IDLE;
          else next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) next_state = ST_CAL;
      end
      ST_IDLE: begin
        if (dn_s) next_state = ST_PWRDN;
        else if (cal_go) next_state = ST_CAL;
      end
      ST_CAL: begin
        if (cal_last) begin
          if (dn_s) next_state = ST_PWRDN;
          else next_state = ST_IDLE;
        end
      end
      ST_PWRDN: begin
        if (!dn_s) next_state = ST_IDLE;
      end
      default: next_state = ST_SYNC;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) state <= ST_SYNC;
    else state <= next_state;
  end

  // waits for the synchronisers to hold real pin levels before deciding
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sync_cnt <= 2'h0;
    else if (state == ST_SYNC && sync_cnt != `ACC_SYNC_FILL) sync_cnt <= sync_cnt + 2'h1;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) dly_cnt <= 32'h0;
    else if (state == ST_DELAY && !dn_s) dly_cnt <= dly_cnt + 32'h1;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cal_cnt <= 16'h0;
    else if (state == ST_CAL) cal_cnt <= cal_cnt + 16'h1;
    else cal_cnt <= 16'h0;
  end

  assign cal_state_o = state;
  assign calibration_active_o = (state == ST_CAL);

  // held powered down until edges have moved the sequencer out of reset
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) analog_power_down_o <= 1'b1;
    else analog_power_down_o <= (next_state == ST_SYNC) || (next_state == ST_PWRDN);
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  always_comb begin
    ev = 4'h0;
    ev[`ACC_EV_START_BIT] = (next_state == ST_CAL) && (state != ST_CAL);
    ev[`ACC_EV_DONE_BIT] = (state == ST_CAL) && (next_state != ST_CAL);
    ev[`ACC_EV_IGNORED_BIT] = cal_go && (state == ST_PWRDN);
    ev[`ACC_EV_DUAL_BIT] = cal_go && dual_s && (state == ST_IDLE);
  end

  // a new event beats a write-one clear in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) irq_status <= 4'h0;
    else if (wr_en && paddr_i == `ACC_IRQ_STATUS_OFF)
      irq_status <= (irq_status & ~pwdata_i[3:0]) | ev;
    else irq_status <= irq_status | ev;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) irq_mask <= `ACC_IRQ_MASK_RST;
    else if (wr_en && paddr_i == `ACC_IRQ_MASK_OFF) irq_mask <= pwdata_i[3:0];
  end

  assign irq_o = |(irq_status & irq_mask);

  // ----------------------------------------
  // apb register file
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cal_len <= `ACC_CAL_LEN_RST;
    else if (wr_en && paddr_i == `ACC_CTRL_OFF) cal_len <= pwdata_i[`ACC_CTRL_LEN_MSB:0];
  end

  // software start behaves like a filtered pin request
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sw_cal <= 1'b0;
    else sw_cal <= wr_en && paddr_i == `ACC_CTRL_OFF && pwdata_i[`ACC_CTRL_SWCAL_BIT];
  end

  // read data captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (rd_setup) begin
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
      unique case (paddr_i)
        `ACC_CTRL_OFF: prdata_o <= {16'h0, cal_len};
        `ACC_STATE_OFF: prdata_o <= {24'h0, dual_s, dn_s, req_s,
                                     analog_power_down_o, calibration_active_o, state};
        `ACC_IRQ_STATUS_OFF: prdata_o <= {28'h0, irq_status};
        `ACC_IRQ_MASK_OFF: prdata_o <= {28'h0, irq_mask};
        default: pslverr_o <= 1'b1;
      endcase
    end
  end

  assign pready_o = psel_i && penable_i;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cal_entry;
    state != ST_CAL ##1 state == ST_CAL;
  endsequence

  sequence s_cal_exit;
    state == ST_CAL ##1 state != ST_CAL;
  endsequence

  a_active_tracks: assert property (s_cal_entry |-> calibration_active_o
      && $past(!calibration_active_o))
    else $error("active indicator not raised on calibration entry");
  a_active_drops: assert property (s_cal_exit |-> !calibration_active_o)
    else $error("active indicator left high after calibration");
  a_delay_start: assert property (state == ST_DELAY && dly_done |=> state == ST_CAL)
    else $error("power-on calibration did not start after delay");
  a_skip_power_on: assert property (state == ST_SYNC && sync_cnt == `ACC_SYNC_FILL
      && req_s |=> state == ST_IDLE)
    else $error("power-on calibration not skipped with request high");
  a_analog_held: assert property (state == ST_SYNC |-> analog_power_down_o)
    else $error("analog section woke before sequencer moved");
  a_delay_select: assert property (!ext_s && dsel_s |-> dly_limit == DLY_LONG_CYC)
    else $error("long delay not chosen by select");
  a_delay_hold: assert property (state == ST_DELAY && dn_s |=> $stable(dly_cnt))
    else $error("delay counter ran during power down");
  a_ext_short: assert property (ext_s |-> dly_limit == DLY_SHORT_CYC)
    else $error("extended mode did not force short delay");
  a_down_defer: assert property (state == ST_CAL && !cal_last && dn_s |=> state == ST_CAL)
    else $error("power down cut calibration short");
  a_down_ignore: assert property (state == ST_PWRDN ##1 state == ST_PWRDN
      |=> state != ST_CAL)
    else $error("calibration started while powered down");
  a_req_start: assert property (deb_start && state == ST_IDLE && !dn_s
      |=> state == ST_CAL ##1 calibration_active_o)
    else $error("filtered request did not start calibration");
endmodule // acc_calibration_control

`default_nettype wire

/* core/acc_edge_align.sv */
// output data clock and output data launch edge
// assumes edge select is already synchronised to core_clk_i
`default_nettype none

module acc_edge_align (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // data path
  input wire logic edge_sel_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_clk_o
);
  // data clock runs at half the sample rate, one word per period
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) data_clk_o <= 1'b0;
    else data_clk_o <= !data_clk_o;
  end

  // word launched with the data clock edge the select asks for
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) data_o <= 8'h00;
    else if (data_clk_o != edge_sel_i) data_o <= data_i;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_edge_launch: assert property ($changed(data_o) |->
      ($rose(data_clk_o) && $past(edge_sel_i)) ||
      ($fell(data_clk_o) && !$past(edge_sel_i)))
    else $error("output data changed on the wrong data clock edge");
endmodule // acc_edge_align

`default_nettype wire

/* core/acc_req_debounce.sv */
// filter of the on-command calibration request
// assumes the request is already synchronised to core_clk_i
`default_nettype none
`include "acc_regs.svh"

module acc_req_debounce (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // request level in, start pulse out
  input wire logic req_i,
  output logic start_o
);
  logic prev;
  logic armed;
  logic [7:0] run_cnt;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= 1'b0;
      run_cnt <= 8'h00;
    end else begin
      prev <= req_i;
      if (req_i != prev) run_cnt <= 8'h01;
      else if (run_cnt != `ACC_DEBOUNCE_LEN) run_cnt <= run_cnt + 8'h01;
    end
  end

  // armed only by a full low run, so a request high at power-up never fires
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) armed <= 1'b0;
    else if (start_o) armed <= 1'b0;
    else if (!req_i && req_i == prev && run_cnt == `ACC_DEBOUNCE_LEN) armed <= 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) start_o <= 1'b0;
    else start_o <= armed && req_i && req_i == prev &&
                    run_cnt == `ACC_DEBOUNCE_LEN - 8'h01;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_start_after_high: assert property (start_o |-> $past(req_i) && $past(armed))
    else $error("start without armed high request");
  a_no_start_glitch: assert property ($past(req_i) != req_i |=> !start_o)
    else $error("start right after a level change");
endmodule // acc_req_debounce

`default_nettype wire

/* shared/acc_pkg.sv */
// types of the converter calibration control block
// assumes nothing beyond the constants header
`default_nettype none

package acc_pkg;
  typedef enum logic [2:0] {
    ST_SYNC = 3'b000,
    ST_DELAY = 3'b001,
    ST_IDLE = 3'b010,
    ST_CAL = 3'b011,
    ST_PWRDN = 3'b100
  } acc_state_t;
endpackage

`default_nettype wire

/* shared/acc_regs.svh */
// constants of the converter calibration control block
// assumes one 100 MHz sample clock and an apb slave port
//
// What this block does
// - calibration active output is high exactly while calibration runs
// - power-on calibration starts by itself after a delay from power-up
// - request high at power-up skips power-on calibration entirely
// - calibration starts 80 cycles after the valid request went high
// - analog section stays powered down until the sample clock runs
// - delay select level chooses short or long power-up delay
// - power-down high at power-up holds the delay counter
// - extended control mode forces the short power-up delay
// - output data changes on rising or falling data clock edge
// - sequence is the same whether clock runs at power-up or later
// - power-down during calibration waits until calibration ends
// - requests are ignored while powered down apart from raising the ignored event
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACC_CTRL_OFF 12'h000
`define ACC_STATE_OFF 12'h004
`define ACC_IRQ_STATUS_OFF 12'h008
`define ACC_IRQ_MASK_OFF 12'h00C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ACC_CTRL_LEN_MSB 15
`define ACC_CTRL_SWCAL_BIT 16
`define ACC_CAL_LEN_RST 16'h0400
`define ACC_IRQ_MASK_RST 4'h0
`define ACC_EV_START_BIT 0
`define ACC_EV_DONE_BIT 1
`define ACC_EV_IGNORED_BIT 2
`define ACC_EV_DUAL_BIT 3

// ----------------------------------------
// timing counts in sample clock cycles
// ----------------------------------------
`define ACC_DEBOUNCE_LEN 8'h50
`define ACC_DLY_SHORT 32'h0100_0000
`define ACC_DLY_LONG 32'h4000_0000
`define ACC_SYNC_FILL 2'h2

`endif

/* test/acc_host_model.sv */
// host-side model that drives the calibration request pin
// assumes the bench pulses go_i for one clock to start a sequence
`default_nettype none

module acc_host_model (
  // clock
  input wire logic core_clk_i,
  // sequence control from the bench
  input wire logic go_i,
  input wire logic [7:0] low_len_i,
  input wire logic [7:0] high_len_i,
  input wire logic idle_lvl_i,
  // pin towards the converter
  output var logic cal_request_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cal_request_o = 1'b0;

  // the host times both runs itself, the device only counts them
  always @(posedge core_clk_i) begin
    if (go_i) begin
      cal_request_o <= 1'b0;
      repeat (low_len_i) @(posedge core_clk_i);
      cal_request_o <= 1'b1;
      repeat (high_len_i) @(posedge core_clk_i);
    end
    cal_request_o <= idle_lvl_i;
  end
endmodule // acc_host_model

`default_nettype wire

/* test/tb.sv */
// self-checking bench of the calibration control block
// assumes the host model and the design files are compiled before it
`default_nettype none
`include "acc_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;

  typedef struct {logic sel; logic ext; logic req; logic late; int dn_hold; int delta;} acc_row_t;

  logic core_clk_i = 1'b0;
  logic clk_run = 1'b1;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, er, cal_request_i, full_power_down_i = 1'b0;
  logic calibration_delay_select_i = 1'b0, output_edge_select_i = 1'b0;
  logic extended_mode_i = 1'b0, go = 1'b0, idle_lvl = 1'b0;
  // host starts with dual-edge mode off so requests are legal
  logic dual_edge_i = 1'b0;
  logic [7:0] sample_data_i = 8'h00, output_data_o, low_len = 8'h00, high_len = 8'h00;
  logic output_data_clock_o, calibration_active_o, analog_power_down_o, irq_o;
  acc_state_t cal_state_o;
  int err_count = 0, n_checks = 0, cyc = 0, t_on, t_len, base;

  // short delays keep power-up runs brief: 20 and 40 cycles
  acc_calibration_control #(.DLY_SHORT_CYC(32'h14), .DLY_LONG_CYC(32'h28)) dut_u (
    .core_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .cal_request_i, .full_power_down_i,
    .calibration_delay_select_i, .output_edge_select_i, .extended_mode_i, .dual_edge_i,
    .sample_data_i, .output_data_o, .output_data_clock_o, .cal_state_o,
    .calibration_active_o, .analog_power_down_o, .irq_o);

  acc_host_model host_u (.core_clk_i(core_clk_i), .go_i(go), .low_len_i(low_len),
    .high_len_i(high_len), .idle_lvl_i(idle_lvl), .cal_request_o(cal_request_i));

  // ----------------------------------------
  // clock, data and timeout
  // ----------------------------------------
  always #5 core_clk_i = clk_run ? ~core_clk_i : core_clk_i;

  always @(posedge core_clk_i) begin
    sample_data_i <= sample_data_i + 8'h01;
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // one idle edge keeps a following call from driving psel twice in a step
    @(posedge core_clk_i);
  endtask

  // t_on: edges until calibration shows, t_len: edges it stays up
  task automatic wait_cal(input int lim, input int dn_t, input logic dn_on);
    t_on = -1;
    t_len = 0;
    for (int t = 1; t <= lim && t_on < 0; t++) begin
      @(posedge core_clk_i);
      if (t == dn_t) full_power_down_i <= 1'b0;
      if (calibration_active_o === 1'b1) t_on = t;
    end
    if (dn_on) full_power_down_i <= 1'b1;
    while (calibration_active_o === 1'b1 && t_len < 3000) begin
      @(posedge core_clk_i);
      t_len++;
    end
  endtask

  task automatic power_up(input acc_row_t r);
    arst_n_i <= 1'b0;
    calibration_delay_select_i <= r.sel;
    extended_mode_i <= r.ext;
    idle_lvl <= r.req;
    full_power_down_i <= (r.dn_hold > 0);
    repeat (3) @(posedge core_clk_i);
    if (r.late) clk_run = 1'b0;
    arst_n_i <= 1'b1;
    if (r.late) begin
      #200;
      chk("analog power-down without clock", 32'h1, 32'(analog_power_down_o));
      clk_run = 1'b1;
    end
    wait_cal(200, r.dn_hold, 1'b0);
  endtask

  // time from pin rise to calibration start is kept in t_on
  task automatic oncmd(input logic [7:0] lo, input logic [7:0] hi, input logic idl,
                       input logic dn_on);
    low_len <= lo;
    high_len <= hi;
    idle_lvl <= idl;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    @(posedge core_clk_i);
    while (cal_request_i !== 1'b1) @(posedge core_clk_i);
    wait_cal(120, 0, dn_on);
  endtask

  // ----------------------------------------
  // power-up cases: delay against the short-delay reference row
  // ----------------------------------------
  acc_row_t rows[6] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 0, 0},
    '{1'b1, 1'b0, 1'b0, 1'b0, 0, 20},
    '{1'b1, 1'b1, 1'b0, 1'b0, 0, 0},
    '{1'b0, 1'b0, 1'b0, 1'b0, 30, 30},
    '{1'b0, 1'b0, 1'b1, 1'b0, 0, -1},
    '{1'b0, 1'b0, 1'b0, 1'b1, 0, 0}
  };

  initial begin
    int exp;
    int tol;
    int chg;
    logic [7:0] prev;
    repeat (3) @(posedge core_clk_i);
    chk("reset state", 32'(ST_SYNC), 32'(cal_state_o));
    chk("reset active", 32'h0, 32'(calibration_active_o));
    chk("reset analog power-down", 32'h1, 32'(analog_power_down_o));
    foreach (rows[i]) begin
      power_up(rows[i]);
      if (i == 0) base = t_on;
      exp = (rows[i].delta < 0) ? -1 : base + rows[i].delta;
      tol = (rows[i].dn_hold > 0) ? 2 : 0;
      chk("power-up start", 32'h1, 32'(t_on >= exp - tol && t_on <= exp + tol));
      if (exp >= 0) chk("power-up length", 32'h400, 32'(t_len));
      chk("idle after power-up", 32'(ST_IDLE), 32'(cal_state_o));
    end
    chk("short delay", 32'h1, 32'(base >= 21 && base <= 26));
    // ----------------------------------------
    // registers and interrupt
    // ----------------------------------------
    apb(1'b0, `ACC_CTRL_OFF, 32'h0);
    chk("ctrl reset", 32'h0000_0400, rd);
    apb(1'b0, `ACC_IRQ_MASK_OFF, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    apb(1'b1, `ACC_CTRL_OFF, 32'h0000_0032);
    apb(1'b1, `ACC_IRQ_MASK_OFF, 32'h0000_000F);
    @(posedge core_clk_i);
    chk("irq unmasked", 32'h1, 32'(irq_o));
    apb(1'b1, `ACC_IRQ_STATUS_OFF, 32'h0000_000F);
    @(posedge core_clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    // ----------------------------------------
    // on-command requests
    // ----------------------------------------
    // host recalibrates on command well after power-up
    oncmd(8'h5A, 8'h5A, 1'b1, 1'b0);
    chk("request to start", 32'h1, 32'(t_on >= 79 && t_on <= 84));
    chk("command length", 32'h32, 32'(t_len));
    apb(1'b0, `ACC_IRQ_STATUS_OFF, 32'h0);
    chk("start and done events", 32'h3, rd);
    apb(1'b1, `ACC_IRQ_STATUS_OFF, 32'h0000_0003);
    oncmd(8'h28, 8'h5A, 1'b1, 1'b0);
    chk("short low run", 32'hFFFF_FFFF, 32'(t_on));
    oncmd(8'h5A, 8'h28, 1'b0, 1'b0);
    chk("short high run", 32'hFFFF_FFFF, 32'(t_on));
    full_power_down_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    chk("powered down", 32'(ST_PWRDN), 32'(cal_state_o));
    oncmd(8'h5A, 8'h5A, 1'b1, 1'b0);
    chk("request in power down", 32'hFFFF_FFFF, 32'(t_on));
    apb(1'b0, `ACC_IRQ_STATUS_OFF, 32'h0);
    chk("ignored event", 32'h4, rd);
    apb(1'b1, `ACC_IRQ_STATUS_OFF, 32'h0000_0004);
    full_power_down_i <= 1'b0;
    oncmd(8'h5A, 8'h5A, 1'b0, 1'b1);
    chk("length under power down", 32'h32, 32'(t_len));
    chk("power down after cal", 32'(ST_PWRDN), 32'(cal_state_o));
    // host breaks the dual-edge rule on purpose: the request runs but is flagged
    full_power_down_i <= 1'b0;
    dual_edge_i <= 1'b1;
    apb(1'b1, `ACC_IRQ_STATUS_OFF, 32'h0000_000F);
    oncmd(8'h5A, 8'h5A, 1'b0, 1'b0);
    dual_edge_i <= 1'b0;
    apb(1'b0, `ACC_IRQ_STATUS_OFF, 32'h0);
    chk("dual-edge event", 32'hB, rd);
    // ----------------------------------------
    // output data launch edge, both selections
    // ----------------------------------------
    for (int s = 0; s < 2; s++) begin
      output_edge_select_i <= s[0];
      repeat (4) @(posedge core_clk_i);
      chg = 0;
      repeat (16) begin
        prev = output_data_o;
        @(posedge core_clk_i);
        if (output_data_o !== prev) begin
          chg++;
          chk("data clock at change", 32'(s), 32'(output_data_clock_o));
        end
      end
      chk("data changes seen", 32'h1, 32'(chg > 0));
    end
    complete_run();
  end
endmodule // tb

`default_nettype wire
